// file: src/dsdl_pkg.sv
// Notes on behaviour
// (R01) Eight display positions hold latched BCD digits
// (R02) Display changes only in first cycle half
// (R03) Each pulse loads next position, lowest first
// (R04) Capture waits a settle delay after pulse
// (R05) Only top four positions may blank
// (R06) Blank only zeros above all nonzero digits
// (R07) Zero level registered on undelayed pulse
// (R08) Nonzero registers low, next pulse resets blanking
// (R09) Controller gives nine pulses per first half
// (R10) Cycle phase low first half, high second
// (R11) Controller sends one BCD digit per pulse
// (R12) Undriven data line reads as one
// (R13) Display holds during the nine trailing pulses
// (R14) Capture overwrites only the selected position
// (R15) Cycle start resets sequencer and blanking
package dsdl_pkg;

  ////////////////////////////////////////////////////////////////
  // Timing
  localparam int         CLK_PERIOD_NS = 20;
  localparam int         SETTLE_NS     = 100;
  // Least time, so round up to whole cycles
  localparam int         SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] SETTLE_LAST   = 3'(SETTLE_CYC - 1);
  localparam logic [2:0] SETTLE_RST    = 3'h0;

  ////////////////////////////////////////////////////////////////
  // Positions and counts
  localparam int         NUM_POS         = 8;
  localparam int         NUM_BLANK       = 4;
  localparam logic [3:0] PULSES_PER_HALF = 4'h9;
  localparam logic [3:0] FIRST_BLANK_POS = 4'h4;
  localparam logic [3:0] LAST_POS        = 4'h7;
  localparam logic [3:0] POS_RST         = 4'h0;
  localparam logic [3:0] DIGIT_RST       = 4'h0;
  localparam logic [3:0] BLANK_RST       = 4'h0;

  ////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic [2:0] pos;
    logic [3:0] digit;
  } dsdl_word_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SETTLE = 3'b010,
    ST_PUSH   = 3'b100
  } dsdl_state_t;

endpackage

// file: src/dsdl_buf2.sv
module dsdl_buf2 (
  input  wire logic                 i_clk,
  input  wire logic                 i_nrst,
  input  wire logic                 i_in_valid,
  output logic                      o_in_ready,
  input  wire dsdl_pkg::dsdl_word_t i_in_word,
  output logic                      o_out_valid,
  input  wire logic                 i_out_ready,
  output dsdl_pkg::dsdl_word_t      o_out_word
);

  dsdl_pkg::dsdl_word_t mem_ff [2];
  logic                 wptr_ff;
  logic                 rptr_ff;
  logic [1:0]           cnt_ff;
  logic                 push;
  logic                 pop;

  ////////////////////////////////////////////////////////////////
  // Handshake; full and empty come straight from the count
  assign o_in_ready  = (cnt_ff != 2'h2);
  assign o_out_valid = (cnt_ff != 2'h0);
  assign o_out_word  = mem_ff[rptr_ff];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // Storage needs no reset, only the pointers and the count do
  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem_ff[wptr_ff] <= i_in_word;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      wptr_ff <= 1'b0;
      rptr_ff <= 1'b0;
      cnt_ff  <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        wptr_ff <= !wptr_ff;
      end
      if (pop)
      begin
        rptr_ff <= !rptr_ff;
      end
      if (push && !pop)
      begin
        cnt_ff <= cnt_ff + 2'h1;
      end
      else if (pop && !push)
      begin
        cnt_ff <= cnt_ff - 2'h1;
      end
    end
  end

  a_buf_bound: assert property (@(posedge i_clk) disable iff (!i_nrst) cnt_ff <= 2'h2)
    else $error("buffer count out of range");

endmodule

// file: src/dsdl_top.sv
module dsdl_top (
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_digit_clock,
  input  wire logic       i_cycle_phase,
  input  wire logic [3:0] i_digit_bcd_bus,
  input  wire logic [3:0] i_digit_bcd_driven,
  input  wire logic       i_display_ready,
  output logic [7:0][3:0] o_digits,
  output logic [3:0]      o_blank
);

  localparam int A_SETTLE = dsdl_pkg::SETTLE_CYC;

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic       clk_m_ff;
  logic       clk_s_ff;
  logic       clk_d_ff;
  logic       ph_m_ff;
  logic       ph_s_ff;
  logic       ph_d_ff;
  logic [3:0] bus_m_ff;
  logic [3:0] bus_s_ff;
  logic [3:0] drv_m_ff;
  logic [3:0] drv_s_ff;

  // Every pin except i_clk, i_nrst and i_display_ready passes two flops before use
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      clk_m_ff <= 1'b0;
      clk_s_ff <= 1'b0;
      clk_d_ff <= 1'b0;
      ph_m_ff  <= 1'b1;
      ph_s_ff  <= 1'b1;
      ph_d_ff  <= 1'b1;
      bus_m_ff <= 4'h0;
      bus_s_ff <= 4'h0;
      drv_m_ff <= 4'h0;
      drv_s_ff <= 4'h0;
    end
    else
    begin
      clk_m_ff <= i_digit_clock;
      clk_s_ff <= clk_m_ff;
      clk_d_ff <= clk_s_ff;
      ph_m_ff  <= i_cycle_phase;
      ph_s_ff  <= ph_m_ff;
      ph_d_ff  <= ph_s_ff;
      bus_m_ff <= i_digit_bcd_bus;
      bus_s_ff <= bus_m_ff;
      drv_m_ff <= i_digit_bcd_driven;
      drv_s_ff <= drv_m_ff;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Decoded events
  logic       pulse;
  logic       cyc_start;
  logic [3:0] digit_now;
  logic       bus_zero;

  assign pulse     = clk_s_ff && !clk_d_ff && !ph_s_ff; // see (R02)
  assign cyc_start = !ph_s_ff && ph_d_ff;
  assign digit_now = bus_s_ff | ~drv_s_ff;               // see (R12)
  assign bus_zero  = (digit_now == 4'h0);                // see (R07)

  // True for the four top positions only
  function automatic logic is_blankable(input logic [3:0] pos);
    is_blankable = (pos >= dsdl_pkg::FIRST_BLANK_POS) && (pos <= dsdl_pkg::LAST_POS); // see (R05)
  endfunction

  ////////////////////////////////////////////////////////////////
  // Position sequencer; extra pulses past nine are ignored
  logic [3:0] pos_ff;

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst || cyc_start)
    begin
      pos_ff <= dsdl_pkg::POS_RST; // see (R15)
    end
    else if (pulse && pos_ff < dsdl_pkg::PULSES_PER_HALF)
    begin
      pos_ff <= pos_ff + 4'h1; // see (R03)
    end
  end

  ////////////////////////////////////////////////////////////////
  // Blanking register, driven by the undelayed pulse
  logic [3:0] blank_ff;
  logic [3:0] nxt_blank;
  logic       pend_ff;
  logic [1:0] bidx;

  assign bidx = 2'(pos_ff - dsdl_pkg::FIRST_BLANK_POS);

  // A pending reset clears the lower bits before the new bit lands
  always_comb
  begin
    nxt_blank = pend_ff ? dsdl_pkg::BLANK_RST : blank_ff; // see (R08)
    if (is_blankable(pos_ff))
    begin
      nxt_blank[bidx] = bus_zero; // see (R06)
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst || cyc_start)
    begin
      blank_ff <= dsdl_pkg::BLANK_RST; // see (R15)
      pend_ff  <= 1'b0;
    end
    else if (pulse && pos_ff < dsdl_pkg::PULSES_PER_HALF)
    begin
      blank_ff <= nxt_blank;                             // see (R07)
      pend_ff  <= is_blankable(pos_ff) && !bus_zero;     // see (R08)
    end
  end

  assign o_blank = blank_ff;

  ////////////////////////////////////////////////////////////////
  // Delayed capture: the bus is sampled only after it settles
  dsdl_pkg::dsdl_state_t state_ff;
  logic [2:0]            cnt_ff;
  logic [2:0]            cap_pos_ff;
  dsdl_pkg::dsdl_word_t  word_ff;
  logic                  cap_fire;
  logic                  buf_in_ready;

  assign cap_fire = (state_ff == dsdl_pkg::ST_SETTLE) && (cnt_ff == dsdl_pkg::SETTLE_LAST);

  // A pulse that lands while a capture is still pending is lost;
  // the pulse spacing of the controller is far above this delay
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      state_ff   <= dsdl_pkg::ST_IDLE;
      cnt_ff     <= dsdl_pkg::SETTLE_RST;
      cap_pos_ff <= 3'h0;
      word_ff    <= '0;
    end
    else
    begin
      unique case (state_ff)
        dsdl_pkg::ST_IDLE:
        begin
          if (pulse && pos_ff <= dsdl_pkg::LAST_POS)
          begin
            state_ff   <= dsdl_pkg::ST_SETTLE; // see (R04)
            cnt_ff     <= dsdl_pkg::SETTLE_RST;
            cap_pos_ff <= pos_ff[2:0];
          end
        end
        dsdl_pkg::ST_SETTLE:
        begin
          cnt_ff <= cnt_ff + 3'h1;
          if (cap_fire)
          begin
            word_ff  <= '{pos: cap_pos_ff, digit: digit_now}; // see (R03)
            state_ff <= dsdl_pkg::ST_PUSH;
          end
        end
        dsdl_pkg::ST_PUSH:
        begin
          // Buffer full stalls the capture here
          if (buf_in_ready)
          begin
            state_ff <= dsdl_pkg::ST_IDLE;
          end
        end
        default:
        begin
          state_ff <= dsdl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Two-entry buffer between capture and display write
  logic                 out_valid;
  logic                 wr_en;
  dsdl_pkg::dsdl_word_t out_word;

  // Writes held off in the second half keep the display still there
  assign wr_en = out_valid && i_display_ready && !ph_s_ff; // see (R13)

  dsdl_buf2 u_buf (
    .i_clk       (i_clk),
    .i_nrst      (i_nrst),
    .i_in_valid  (state_ff == dsdl_pkg::ST_PUSH),
    .o_in_ready  (buf_in_ready),
    .i_in_word   (word_ff),
    .o_out_valid (out_valid),
    .i_out_ready (wr_en),
    .o_out_word  (out_word)
  );

  ////////////////////////////////////////////////////////////////
  // Display positions: one nibble written, all others kept
  logic [7:0][3:0] digits_ff;

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      digits_ff <= {dsdl_pkg::NUM_POS{dsdl_pkg::DIGIT_RST}};
    end
    else if (wr_en)
    begin
      digits_ff[out_word.pos] <= out_word.digit; // see (R01) (R14)
    end
  end

  assign o_digits = digits_ff;

  ////////////////////////////////////////////////////////////////
  // Checks
  a_capture_delay: assert property (@(posedge i_clk) disable iff (!i_nrst) // see (R04)
    (pulse && state_ff == dsdl_pkg::ST_IDLE && pos_ff <= dsdl_pkg::LAST_POS) |-> ##A_SETTLE cap_fire)
    else $error("capture not taken after settle delay");

  a_float_high: assert property (@(posedge i_clk) disable iff (!i_nrst) // see (R12)
    cap_fire |=> ((word_ff.digit | $past(drv_s_ff)) == 4'hf)
      && ((word_ff.digit & $past(drv_s_ff)) == ($past(bus_s_ff) & $past(drv_s_ff))))
    else $error("undriven line not read as one");

  a_write_target: assert property (@(posedge i_clk) disable iff (!i_nrst) // see (R01) (R14)
    wr_en |=> o_digits[$past(out_word.pos)] == $past(out_word.digit))
    else $error("display write missed its position");

  a_no_stray_write: assert property (@(posedge i_clk) disable iff (!i_nrst) // see (R14)
    !wr_en |=> $stable(o_digits))
    else $error("display changed without a write");

  a_second_half_hold: assert property (@(posedge i_clk) disable iff (!i_nrst) // see (R02) (R13)
    (ph_s_ff && ph_d_ff) [*2] |=> $stable(o_digits) && $stable(o_blank))
    else $error("display changed in second half");

  a_pos_step: assert property (@(posedge i_clk) disable iff (!i_nrst) // see (R03)
    (pulse && !cyc_start && pos_ff < dsdl_pkg::PULSES_PER_HALF) |=> pos_ff == $past(pos_ff) + 4'h1)
    else $error("sequencer did not advance");

  a_zero_track: assert property (@(posedge i_clk) disable iff (!i_nrst) // see (R07)
    (pulse && pos_ff == dsdl_pkg::FIRST_BLANK_POS) |=> blank_ff[0] == $past(bus_zero))
    else $error("zero level not registered");

  a_nonzero_low: assert property (@(posedge i_clk) disable iff (!i_nrst) // see (R08)
    (pulse && !cyc_start && is_blankable(pos_ff) && !bus_zero) |=> pend_ff && !blank_ff[$past(bidx)])
    else $error("nonzero digit left blanking high");

  a_blank_reset: assert property (@(posedge i_clk) disable iff (!i_nrst) // see (R06) (R08)
    (pulse && !cyc_start && pend_ff && pos_ff < dsdl_pkg::PULSES_PER_HALF) |=> $countones(blank_ff) <= 1)
    else $error("blanking register not reset");

  a_cycle_restart: assert property (@(posedge i_clk) disable iff (!i_nrst) // see (R15)
    cyc_start |=> pos_ff == dsdl_pkg::POS_RST && blank_ff == dsdl_pkg::BLANK_RST && !pend_ff)
    else $error("cycle start did not reset sequencer");

  c_full_load: cover property (@(posedge i_clk) disable iff (!i_nrst)
    pulse && pos_ff == 4'h8);
  c_buf_stall: cover property (@(posedge i_clk) disable iff (!i_nrst)
    state_ff == dsdl_pkg::ST_PUSH && !buf_in_ready);
  c_top_blank: cover property (@(posedge i_clk) disable iff (!i_nrst)
    blank_ff[3] && !ph_s_ff && ph_m_ff);
  c_reset_blank: cover property (@(posedge i_clk) disable iff (!i_nrst)
    pulse && pend_ff && blank_ff != 4'h0);

endmodule

// file: tb/dsdl_ctl_model.sv
// Timing and control unit: sends one digit-serial data cycle on request
module dsdl_ctl_model (
  input  wire logic       i_clk,
  output logic            o_digit_clock,
  output logic            o_cycle_phase,
  output logic [3:0]      o_bus,
  output logic [3:0]      o_driven
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle: second half, all lines driven
  initial
  begin
    o_digit_clock = 1'b0;
    o_cycle_phase = 1'b1;
    o_bus         = 4'h0;
    o_driven      = 4'hf;
  end
  // Move just after an edge, so the block never races the model
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Data settles 2 clk before the rise and stays for 10 clk after, then scrambles
  // Undriven lines show the inverse, since nothing pulls them
  task automatic pulse(input logic [3:0] d);
    o_bus = d ^ ~o_driven;
    step(2);
    o_digit_clock = 1'b1;
    step(4);
    o_digit_clock = 1'b0;
    step(6);
    o_bus = ~o_bus;
    step(4);
  endtask
  // n pulses in the first half (nine when legal), nine more in the second half
  task automatic run_cycle(input logic [7:0][3:0] d, input int n, input logic [3:0] drv);
    o_driven      = drv;
    o_cycle_phase = 1'b0;
    step(4);
    for (int i = 0; i < n; i++)
    begin
      pulse((i < 8) ? d[i] : ((i == 8) ? 4'h0 : 4'h5));
    end
    o_driven      = 4'hf;
    o_cycle_phase = 1'b1;
    step(4);
    // Trailing pulses carry junk that must never reach the display
    for (int i = 0; i < 9; i++)
    begin
      pulse(4'h1);
    end
  endtask
endmodule

// file: tb/testbench.sv
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fails++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic            i_clk;
  logic            i_nrst;
  logic            i_display_ready;
  logic            dclk;
  logic            phase;
  logic [3:0]      bus;
  logic [3:0]      drv;
  logic [7:0][3:0] o_digits;
  logic [3:0]      o_blank;
  logic [7:0][3:0] prev;
  int              fails  = 0;
  int              checks = 0;
  dsdl_top i_dut (
    .i_clk              (i_clk),
    .i_nrst             (i_nrst),
    .i_digit_clock      (dclk),
    .i_cycle_phase      (phase),
    .i_digit_bcd_bus    (bus),
    .i_digit_bcd_driven (drv),
    .i_display_ready    (i_display_ready),
    .o_digits           (o_digits),
    .o_blank            (o_blank)
  );
  dsdl_ctl_model i_ctl (
    .i_clk         (i_clk),
    .o_digit_clock (dclk),
    .o_cycle_phase (phase),
    .o_bus         (bus),
    .o_driven      (drv)
  );
  // 50 MHz clock
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  ////////////////////////////////////////////////////////////////
  // Blank bit i is set while positions 4+i up to 7 are all zero
  function automatic logic [3:0] lead(input logic [7:0][3:0] d);
    logic z;
    z = 1'b1;
    for (int i = 7; i >= 4; i--)
    begin
      z         = z & (d[i] == 4'h0);
      lead[i-4] = z;
    end
  endfunction
  // One full cycle, judged after the second half has passed
  task automatic full(input logic [7:0][3:0] d, input logic [3:0] dr, input int n);
    logic [7:0][3:0] e;
    for (int i = 0; i < 8; i++)
    begin
      e[i] = d[i] | ~dr;
    end
    i_ctl.run_cycle(d, n, dr);
    `CHK("digits", e, o_digits)
    `CHK("blank", lead(e), o_blank)
    prev = o_digits;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_preset();
    full(32'h0300_0000, 4'hf, 9);
  endtask
  // Zero under a nonzero, nonzero on top, all zero
  task automatic t_blank();
    logic [7:0][3:0] tbl [3];
    tbl = '{32'h0030_0009, 32'h9000_0000, 32'h0000_0000};
    for (int k = 0; k < 3; k++)
    begin
      full(tbl[k], 4'hf, 9);
    end
  endtask
  // Three pulses only: rest keeps the old digits, blanking starts cleared
  task automatic t_partial();
    logic [7:0][3:0] e;
    e      = prev;
    e[2:0] = 12'h234;
    i_ctl.run_cycle(32'h1111_1234, 3, 4'hf);
    `CHK("partial digits", e, o_digits)
    `CHK("partial blank", 4'h0, o_blank)
  endtask
  // A tenth pulse must be ignored
  task automatic t_extra();
    full(32'h1234_5678, 4'hf, 10);
  endtask
  // Two floating lines read as ones
  task automatic t_float();
    full(32'h0000_0000, 4'b1010, 9);
  endtask
  // Display stalls long enough to fill the buffer and hold a capture back
  task automatic t_stall();
    fork
      full(32'h0987_6543, 4'hf, 9);
      begin
        repeat (40) @(posedge i_clk);
        #1 i_display_ready = 1'b0;
        repeat (40) @(posedge i_clk);
        #1 i_display_ready = 1'b1;
      end
    join
  endtask
  task automatic tally_and_finish();
    if (fails == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence: reset 20 cycles, let synchronisers settle
  initial
  begin
    i_nrst          = 1'b0;
    i_display_ready = 1'b1;
    repeat (20) @(posedge i_clk);
    #1 i_nrst = 1'b1;
    repeat (4) @(posedge i_clk);
    #1;
    `CHK("reset digits", 32'h0000_0000, o_digits)
    `CHK("reset blank", 4'h0, o_blank)
    t_preset();
    t_blank();
    t_partial();
    t_extra();
    t_float();
    t_stall();
    tally_and_finish();
  end
  // Watchdog: a full nine-pulse cycle takes about 300 clk
  initial
  begin
    repeat (20000) @(posedge i_clk);
    fails++;
    tally_and_finish();
  end
endmodule
